// ==== rtl/optm_top.sv ====
// Behaviour
// R1: delay equals delay count times the shared delay tick period.
// R2: delay count accepts 0 through 4095.
// R3: delay tick period in microseconds, default and minimum one.
// R4: one delay tick period serves all four timers.
// R5: microsecond delay write derives and stores the delay count.
// R6: unreachable microsecond delay rounds to the nearest achievable value.
// R7: direct delay count change updates the microsecond delay view.
// R8: software writes delay microseconds as multiples of the tick period.
// R9: pulse width equals duration count times shared duration tick period.
// R10: duration count accepts 1 through 4095, never zero.
// R11: duration tick period in microseconds, default one, unit steps.
// R12: one duration tick period serves all four timers.
// R13: microsecond duration write derives and stores the duration count.
// R14: duration microsecond read returns count times duration tick period.
// R15: direct duration count change updates the microsecond duration view.
// R16: software writes duration microseconds as multiples of tick period.
// R17: timer select chooses which timer later accesses touch.
// R18: on start wait delay, drive high for duration, then low.
// R19: only exposure start starts a timer.
// R20: timer n drives only output line n.
// R21: start while delaying or pulsing is ignored until idle.
// R22: a one-microsecond tick from the clock paces all counting.
module optm_top import optm_pkg::*; #(
  parameter int N_TIMERS = NUM_TIMERS
) (
  // clock and reset
  input  wire logic                sys_clk,
  input  wire logic                reset,
  // register bus
  input  wire logic [ADDR_W-1:0]   avs_address,
  input  wire logic                avs_read,
  input  wire logic                avs_write,
  input  wire logic [DATA_W-1:0]   avs_writedata,
  output logic      [DATA_W-1:0]   avs_readdata,
  output logic                     avs_waitrequest,
  // camera side
  input  wire logic                exposure_active,
  output logic      [N_TIMERS-1:0] timer_out
);

  localparam int SEL_W = (N_TIMERS > 1) ? $clog2(N_TIMERS) : 1;
  localparam int CNT_W = $clog2(DIVD_W + 1);
  localparam int TCK_W = $clog2(TICK_CYC + 1);
  localparam int PAD_W = DATA_W - US_W;

  typedef enum logic [1:0] {BUS_IDLE, BUS_DIV, BUS_ACK} optm_bus_t;

  // ==========================================================
  // storage
  optm_bus_t          bus_reg, bus_next;
  logic               wait_reg;
  logic [DATA_W-1:0]  rdata_reg;
  logic [SEL_W-1:0]   sel_reg;
  optm_tb_t           tb_reg;
  optm_cfg_t          cfg_reg [N_TIMERS];
  optm_cfg_t          cfg_next;
  logic [TB_W:0]      rem_reg;
  logic [DIVD_W-1:0]  quo_reg;
  logic [TB_W-1:0]    dtb_reg;
  logic [CNT_W-1:0]   dcnt_reg;
  logic [TCK_W-1:0]   tick_cnt_reg;
  logic               us_tick_reg;
  logic               exp_q_reg;
  logic [N_TIMERS-1:0] busy_w;

  // ==========================================================
  // microsecond tick
  wire logic tick_wrap = (tick_cnt_reg == TCK_W'(TICK_CYC - 1));

  // R22: prescaler gives one tick per microsecond
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      tick_cnt_reg <= '0;
      us_tick_reg  <= 1'b0;
    end else begin
      tick_cnt_reg <= tick_wrap ? '0 : tick_cnt_reg + 1'b1;
      us_tick_reg  <= tick_wrap;
    end
  end

  // ==========================================================
  // exposure start edge
  // R19: exposure start is the only trigger
  wire logic exp_start = exposure_active && !exp_q_reg;

  always_ff @(posedge sys_clk) begin
    if (reset) exp_q_reg <= 1'b0;
    else       exp_q_reg <= exposure_active;
  end

  // ==========================================================
  // selected timer views
  wire optm_cfg_t       cur_cfg = cfg_reg[sel_reg];
  // R7: delay view tracks count
  // R15: duration view tracks count
  // R14: microsecond views are always count times period
  wire logic [US_W-1:0] dly_us  = optm_us_of(cur_cfg.delay_raw,
                                             tb_reg.delay_tb);
  wire logic [US_W-1:0] dur_us  = optm_us_of(cur_cfg.dur_raw,
                                             tb_reg.dur_tb);

  wire logic is_us_addr = (avs_address == OFS_DLY_US) ||
                          (avs_address == OFS_DUR_US);
  wire logic req        = avs_read || avs_write;
  wire logic wr_go      = (bus_reg == BUS_ACK) && avs_write;

  wire logic [DATA_W-1:0] rd_mux =
    (avs_address == OFS_SEL)     ? DATA_W'(sel_reg) :
    (avs_address == OFS_DLY_TB)  ? DATA_W'(tb_reg.delay_tb) :
    (avs_address == OFS_DUR_TB)  ? DATA_W'(tb_reg.dur_tb) :
    (avs_address == OFS_DLY_RAW) ? DATA_W'(cur_cfg.delay_raw) :
    (avs_address == OFS_DLY_US)  ? {{PAD_W{1'b0}}, dly_us} :
    (avs_address == OFS_DUR_RAW) ? DATA_W'(cur_cfg.dur_raw) :
    (avs_address == OFS_DUR_US)  ? {{PAD_W{1'b0}}, dur_us} :
    (avs_address == OFS_STATUS)  ? DATA_W'({busy_w, timer_out}) :
                                   '0;

  // ==========================================================
  // rounding divider for microsecond writes
  wire logic [TB_W-1:0]   wr_tb   = (avs_address == OFS_DLY_US) ?
                                    tb_reg.delay_tb : tb_reg.dur_tb;
  // R6: adding half a period rounds to the nearest count
  wire logic [DIVD_W-1:0] dividend =
    DIVD_W'(avs_writedata[US_W-1:0]) + DIVD_W'(wr_tb >> 1);
  wire logic [TB_W:0]     shifted = {rem_reg[TB_W-1:0],
                                     quo_reg[DIVD_W-1]};
  wire logic              fits    = shifted >= {1'b0, dtb_reg};
  wire logic              div_end = (dcnt_reg == CNT_W'(1));
  wire logic [RAW_W-1:0]  div_raw = optm_sat_raw(DATA_W'(quo_reg));

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rem_reg  <= '0;
      quo_reg  <= '0;
      dtb_reg  <= TB_RST;
      dcnt_reg <= '0;
    end else if (bus_reg == BUS_IDLE) begin
      rem_reg  <= '0;
      quo_reg  <= dividend;
      dtb_reg  <= wr_tb;
      dcnt_reg <= CNT_W'(DIVD_W);
    end else if (bus_reg == BUS_DIV) begin
      rem_reg  <= fits ? shifted - {1'b0, dtb_reg} : shifted;
      quo_reg  <= {quo_reg[DIVD_W-2:0], fits};
      dcnt_reg <= dcnt_reg - 1'b1;
    end
  end

  // ==========================================================
  // bus sequencer
  // long writes stall on waitrequest instead of a divider per port
  always_comb begin
    bus_next = bus_reg;
    unique case (bus_reg)
      BUS_IDLE: if (req)
        bus_next = (avs_write && is_us_addr) ? BUS_DIV : BUS_ACK;
      BUS_DIV:  if (div_end) bus_next = BUS_ACK;
      BUS_ACK:  bus_next = BUS_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      bus_reg   <= BUS_IDLE;
      wait_reg  <= 1'b1;
      rdata_reg <= '0;
    end else begin
      bus_reg  <= bus_next;
      wait_reg <= (bus_next != BUS_ACK);
      if (bus_reg == BUS_IDLE && avs_read) rdata_reg <= rd_mux;
    end
  end

  assign avs_readdata    = rdata_reg;
  assign avs_waitrequest = wait_reg;

  // ==========================================================
  // configuration writes
  always_comb begin
    cfg_next = cur_cfg;
    case (avs_address)
      // R2: raw delay saturates at the top of range
      OFS_DLY_RAW: cfg_next.delay_raw = optm_sat_raw(avs_writedata);
      // R5: count derived from microseconds
      OFS_DLY_US:  cfg_next.delay_raw = div_raw;
      // R10: duration never below one
      OFS_DUR_RAW: cfg_next.dur_raw =
        (avs_writedata == '0) ? DUR_MIN : optm_sat_raw(avs_writedata);
      // R13: count derived from microseconds
      OFS_DUR_US:  cfg_next.dur_raw =
        (div_raw == '0) ? DUR_MIN : div_raw;
      default:     cfg_next = cur_cfg;
    endcase
  end

  wire logic wr_cfg = wr_go && (avs_address == OFS_DLY_RAW ||
                      avs_address == OFS_DUR_RAW || is_us_addr);
  // R11: duration period floor
  // R3: a zero period write is stored as one, so it reads back as one
  wire logic [TB_W-1:0] tb_wr = (avs_writedata[TB_W-1:0] == '0) ?
                                TB_MIN : avs_writedata[TB_W-1:0];

  // R4: one shared delay period
  // R12: one shared duration period
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      tb_reg.delay_tb <= TB_RST;
      tb_reg.dur_tb   <= TB_RST;
      sel_reg         <= '0;
    end else if (wr_go) begin
      if (avs_address == OFS_DLY_TB) tb_reg.delay_tb <= tb_wr;
      if (avs_address == OFS_DUR_TB) tb_reg.dur_tb   <= tb_wr;
      if (avs_address == OFS_SEL)
        sel_reg <= avs_writedata[SEL_W-1:0];
    end
  end

  // R17: only the selected timer is written
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      for (int i = 0; i < N_TIMERS; i++) begin
        cfg_reg[i].delay_raw <= DLY_RAW_RST;
        cfg_reg[i].dur_raw   <= DUR_RAW_RST;
      end
    end else if (wr_cfg) begin
      cfg_reg[sel_reg] <= cfg_next;
    end
  end

  // ==========================================================
  // timers
  // R20: timer n owns line n only
  for (genvar g = 0; g < N_TIMERS; g++) begin : g_tmr
    optm_chan u_chan (
      .sys_clk  (sys_clk),
      .reset    (reset),
      .us_tick  (us_tick_reg),
      .start    (exp_start),
      .cfg      (cfg_reg[g]),
      .tb       (tb_reg),
      .line_out (timer_out[g]),
      .busy     (busy_w[g])
    );
  end

  // ==========================================================
  // checks
  wire logic [SEL_W-1:0] other_sel = sel_reg + 1'b1;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  a_tick_spacing: assert property ( // R22
    us_tick_reg |=> !us_tick_reg [*8])
    else $error("microsecond ticks too close");
  a_dly_tb_min: assert property ( // R3
    tb_reg.delay_tb >= TB_MIN && tb_reg.dur_tb >= TB_MIN)
    else $error("tick period fell below one");
  a_dur_raw_min: assert property ( // R10
    cur_cfg.dur_raw >= DUR_MIN)
    else $error("duration count is zero");
  a_dur_us_read: assert property ( // R14
    bus_reg == BUS_ACK && avs_read && avs_address == OFS_DUR_US
    |-> avs_readdata == {{PAD_W{1'b0}}, dur_us})
    else $error("duration view is not count times period");
  a_div_bounded: assert property ( // R13
    bus_reg == BUS_IDLE && avs_write && is_us_addr
    |=> bus_reg == BUS_DIV ##[1:40] !avs_waitrequest)
    else $error("microsecond write never answered");
  a_raw_updates_us: assert property ( // R7
    wr_go && avs_address == OFS_DLY_RAW
    && avs_writedata <= DATA_W'(RAW_MAX)
    |=> dly_us == optm_us_of($past(avs_writedata[RAW_W-1:0]),
                             tb_reg.delay_tb))
    else $error("delay view missed a raw write");
  a_sel_only_target: assert property ( // R17
    wr_cfg && N_TIMERS > 1 |=> $stable(cfg_reg[other_sel]))
    else $error("write reached an unselected timer");

  c_us_write: cover property (wr_go && avs_address == OFS_DUR_US);
  c_start_seen: cover property (exp_start && busy_w == '0);
  c_all_busy: cover property (&busy_w);
endmodule

// ==== include/optm_pkg.sv ====
package optm_pkg;

  // ==========================================================
  // sizes
  localparam int NUM_TIMERS = 4;
  localparam int RAW_W      = 12;
  localparam int TB_W       = 16;
  localparam int US_W       = RAW_W + TB_W;
  localparam int DATA_W     = 32;
  localparam int ADDR_W     = 5;
  localparam int DIVD_W     = US_W + 1;

  // ==========================================================
  // register offsets (byte addresses)
  localparam logic [ADDR_W-1:0] OFS_SEL     = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_DLY_TB  = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_DUR_TB  = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_DLY_RAW = 5'h0C;
  localparam logic [ADDR_W-1:0] OFS_DLY_US  = 5'h10;
  localparam logic [ADDR_W-1:0] OFS_DUR_RAW = 5'h14;
  localparam logic [ADDR_W-1:0] OFS_DUR_US  = 5'h18;
  localparam logic [ADDR_W-1:0] OFS_STATUS  = 5'h1C;

  // ==========================================================
  // limits and reset values
  localparam logic [RAW_W-1:0] RAW_MAX     = 12'hFFF;
  localparam logic [RAW_W-1:0] DUR_MIN     = 12'h001;
  localparam logic [RAW_W-1:0] DLY_RAW_RST = 12'h000;
  localparam logic [RAW_W-1:0] DUR_RAW_RST = 12'h001;
  localparam logic [TB_W-1:0]  TB_MIN      = 16'h0001;
  localparam logic [TB_W-1:0]  TB_RST      = 16'h0001;

  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int US_NS         = 1000;
  localparam int TICK_CYC      = (US_NS / CLK_PERIOD_NS < 1) ? 1 :
                                 US_NS / CLK_PERIOD_NS;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic [RAW_W-1:0] delay_raw;
    logic [RAW_W-1:0] dur_raw;
  } optm_cfg_t;

  typedef struct packed {
    logic [TB_W-1:0] delay_tb;
    logic [TB_W-1:0] dur_tb;
  } optm_tb_t;

  // ==========================================================
  // helpers
  function automatic logic [US_W-1:0] optm_us_of(
    input logic [RAW_W-1:0] raw,
    input logic [TB_W-1:0]  tb);
    optm_us_of = US_W'(raw) * US_W'(tb);
  endfunction

  function automatic logic [RAW_W-1:0] optm_sat_raw(
    input logic [DATA_W-1:0] v);
    optm_sat_raw = (v > DATA_W'(RAW_MAX)) ? RAW_MAX : v[RAW_W-1:0];
  endfunction

endpackage

// ==== rtl/optm_chan.sv ====
module optm_chan import optm_pkg::*; (
  // clock and reset
  input  wire logic      sys_clk,
  input  wire logic      reset,
  // timing and start
  input  wire logic      us_tick,
  input  wire logic      start,
  input  wire optm_cfg_t cfg,
  input  wire optm_tb_t  tb,
  // line
  output logic           line_out,
  output logic           busy
);

  typedef enum logic [1:0] {CH_IDLE, CH_DELAY, CH_PULSE} optm_ch_t;

  optm_ch_t          state_reg, state_next;
  logic [TB_W-1:0]   sub_reg, sub_next;
  logic [RAW_W-1:0]  raw_reg, raw_next;
  logic              out_reg;

  // ==========================================================
  // phase counting
  wire logic [TB_W-1:0]  tb_sel  = (state_reg == CH_DELAY) ?
                                   tb.delay_tb : tb.dur_tb;
  wire logic [RAW_W-1:0] raw_tgt = (state_reg == CH_DELAY) ?
                                   cfg.delay_raw : cfg.dur_raw;
  wire logic [TB_W:0]    sub_inc = {1'b0, sub_reg} + 1'b1;
  wire logic [RAW_W:0]   raw_inc = {1'b0, raw_reg} + 1'b1;
  // >= keeps a run finite if software shrinks a count mid-phase
  wire logic sub_end   = us_tick && (sub_inc >= {1'b0, tb_sel});
  wire logic phase_end = sub_end && (raw_inc >= {1'b0, raw_tgt});

  always_comb begin
    state_next = state_reg;
    sub_next   = sub_reg;
    raw_next   = raw_reg;
    unique case (state_reg)
      // R21: start only taken in idle
      CH_IDLE: if (start) begin
        sub_next   = '0;
        raw_next   = '0;
        // R18: zero delay goes straight high
        state_next = (cfg.delay_raw == '0) ? CH_PULSE : CH_DELAY;
      end
      // R1: delay is count times tick period
      // R9: pulse is count times tick period
      CH_DELAY, CH_PULSE: if (phase_end) begin
        sub_next   = '0;
        raw_next   = '0;
        state_next = (state_reg == CH_DELAY) ? CH_PULSE : CH_IDLE;
      end else if (sub_end) begin
        sub_next = '0;
        raw_next = raw_inc[RAW_W-1:0];
      end else if (us_tick) begin
        sub_next = sub_inc[TB_W-1:0];
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_reg <= CH_IDLE;
      sub_reg   <= '0;
      raw_reg   <= '0;
      out_reg   <= 1'b0;
    end else begin
      state_reg <= state_next;
      sub_reg   <= sub_next;
      raw_reg   <= raw_next;
      out_reg   <= (state_next == CH_PULSE);
    end
  end

  assign line_out = out_reg;
  assign busy     = (state_reg != CH_IDLE);

  // ==========================================================
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  a_zero_delay_rise: assert property ( // R18
    state_reg == CH_IDLE && start && cfg.delay_raw == '0 |=> line_out)
    else $error("zero delay did not raise the line");
  a_delay_holds_low: assert property ( // R1
    state_reg == CH_IDLE && start && cfg.delay_raw != '0
    |=> !line_out && state_reg == CH_DELAY)
    else $error("nonzero delay did not wait low");
  a_start_ignored_busy: assert property ( // R21
    state_reg == CH_PULSE && start && !phase_end |=> state_reg == CH_PULSE)
    else $error("start disturbed a running pulse");
  a_pulse_needs_tick: assert property ( // R9
    line_out && !us_tick |=> line_out)
    else $error("pulse ended without a tick");
  a_fall_on_tick: assert property ( // R18
    $fell(line_out) |-> $past(us_tick))
    else $error("line fell off the tick");

  c_pulse_seen: cover property ($rose(line_out));
  c_busy_restart: cover property (busy && start);
endmodule

// ==== test/optm_cam_model.sv ====
module optm_cam_model import optm_pkg::*; #(
  parameter int EXP_CYC = 4
) (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             reset,
  // bench command
  input  wire logic             fire,
  // camera side
  input  wire logic [3:0]       timer_out,
  output logic                  exposure_active,
  // pulse measurements, in cycles
  output logic [3:0]            meas_valid,
  output logic [3:0][15:0]      meas_dly,
  output logic [3:0][15:0]      meas_wid
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [15:0]      cyc = '0;
  logic [15:0]      len;
  logic [3:0][15:0] t0;
  logic [3:0][15:0] t1;
  logic [3:0]       pend;
  logic [3:0]       prev;

  // ==========================================================
  // exposure source and line watcher
  always @(posedge sys_clk) begin
    cyc <= cyc + 16'h1;
    prev <= timer_out;
    meas_valid <= '0;
    if (reset) begin
      exposure_active <= 1'b0;
      len <= '0;
      pend <= '0;
    end else begin
      // short exposure so a second start can follow soon
      exposure_active <= fire || len > 16'h1;
      len <= fire ? 16'(EXP_CYC) : (len == '0 ? '0 : len - 16'h1);
      for (int i = 0; i < 4; i++) begin
        // a busy line keeps its first start time
        if (fire && !pend[i]) begin
          t0[i] <= cyc;
          pend[i] <= 1'b1;
        end
        if (timer_out[i] && !prev[i])
          t1[i] <= cyc;
        if (!timer_out[i] && prev[i]) begin
          meas_valid[i] <= 1'b1;
          meas_dly[i] <= t1[i] - t0[i];
          meas_wid[i] <= cyc - t1[i];
          pend[i] <= 1'b0;
        end
      end
    end
  end
endmodule

// ==== test/optm_top_tb.sv ====
module optm_top_tb;
  import optm_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  typedef struct packed {
    logic [1:0]  line;
    logic [15:0] lo;
    logic [15:0] hi;
    logic [15:0] wid;
  } optm_exp_t;

  logic                sys_clk = 1'b0;
  logic                reset = 1'b1;
  logic [ADDR_W-1:0]   avs_address = '0;
  logic                avs_read = 1'b0;
  logic                avs_write = 1'b0;
  logic [DATA_W-1:0]   avs_writedata = '0;
  logic [DATA_W-1:0]   avs_readdata;
  logic                avs_waitrequest;
  logic                fire = 1'b0;
  logic                exposure_active;
  logic [3:0]          timer_out;
  logic [3:0]          meas_valid;
  logic [3:0][15:0]    meas_dly;
  logic [3:0][15:0]    meas_wid;
  logic [DATA_W-1:0]   rdq[$];
  optm_exp_t           pq[$];
  int                  errors = 0;
  int                  num_checks = 0;

  always #10 sys_clk = ~sys_clk;

  optm_top i_optm_top (.sys_clk, .reset, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
    .exposure_active, .timer_out);

  optm_cam_model i_optm_cam_model (.sys_clk, .reset, .fire, .timer_out,
    .exposure_active, .meas_valid, .meas_dly, .meas_wid);

  // ==========================================================
  // compare and report
  task automatic bad(input string m);
    errors++;
    $display("BAD t=%0t %s", $time, m);
  endtask

  task automatic chk_rd(input logic [DATA_W-1:0] got, exp);
    num_checks++;
    if (got !== exp)
      bad($sformatf("read %h exp %h", got, exp));
  endtask

  task automatic chk_pulse(input int ln, input logic [15:0] d, w,
                           input optm_exp_t e);
    num_checks++;
    if ($isunknown(d) || e.line !== 2'(ln) || d < e.lo || d > e.hi ||
        w !== e.wid)
      bad($sformatf("line %0d dly %0d wid %0d", ln, d, w));
  endtask

  task automatic end_of_test;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ==========================================================
  // bus master: hold until waitrequest low, idle one cycle after
  task automatic bus(input logic [ADDR_W-1:0] a, input logic w,
                     input logic [DATA_W-1:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 100);
    if (n >= 100)
      bad("bus hang");
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input int d);
    bus(a, 1'b1, 32'(d));
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input int e);
    rdq.push_back(32'(e));
    bus(a, 1'b0, '0);
  endtask

  // ==========================================================
  // result watcher
  always @(posedge sys_clk) begin
    if (avs_read && avs_waitrequest === 1'b0) begin
      if (rdq.size() == 0)
        bad("stray read");
      else
        chk_rd(avs_readdata, rdq.pop_front());
    end
    for (int i = 0; i < 4; i++)
      if (meas_valid[i] === 1'b1) begin
        if (pq.size() == 0)
          bad("stray pulse");
        else
          chk_pulse(i, meas_dly[i], meas_wid[i], pq.pop_front());
      end
  end

  // ==========================================================
  // pulse run; delays given in rising order so falls come in order
  task automatic pulses(input int dtb, wtb, dur, input int dr[4]);
    int n;
    n = 0;
    wr(OFS_DLY_TB, dtb);
    wr(OFS_DUR_TB, wtb);
    for (int i = 0; i < 4; i++) begin
      wr(OFS_SEL, i);
      wr(OFS_DLY_RAW, dr[i]);
      wr(OFS_DUR_RAW, dur);
    end
    for (int i = 0; i < 4; i++)
      pq.push_back({2'(i), 16'(dr[i] == 0 ? 2 : (dr[i]*dtb-1)*TICK_CYC+2),
        16'(dr[i]*dtb*TICK_CYC+5), 16'(dur*wtb*TICK_CYC)});
    // start lands on a tick edge, so a zero-delay pulse spans whole ticks
    @(posedge sys_clk iff i_optm_top.us_tick_reg === 1'b1);
    repeat (TICK_CYC - 2) @(posedge sys_clk);
    fire <= 1'b1;
    @(posedge sys_clk);
    fire <= 1'b0;
    repeat (5) @(posedge sys_clk);
    rd(OFS_STATUS, dr[0] == 0 ? 32'hF1 : 32'hF0);
    // second start while busy must not add pulses
    fire <= 1'b1;
    @(posedge sys_clk);
    fire <= 1'b0;
    while (pq.size() > 0 && n < 5000) begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= 5000)
      bad("pulse wait");
    repeat (100) @(posedge sys_clk);
    $display("test pulses done");
  endtask

  // ==========================================================
  // main sequence
  initial begin
    int t;
    int r;
    int d;
    void'($urandom(32'hB7188847));
    repeat (10) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    rd(OFS_SEL, 0);
    rd(OFS_DLY_TB, 1);
    rd(OFS_DUR_TB, 1);
    rd(OFS_DLY_RAW, 0);
    rd(OFS_DUR_RAW, 1);
    rd(OFS_DLY_US, 0);
    rd(OFS_DUR_US, 1);
    rd(OFS_STATUS, 0);
    rd(5'h02, 0);
    $display("test reset values done");
    wr(OFS_DLY_RAW, 4095);
    rd(OFS_DLY_RAW, 4095);
    wr(OFS_DUR_RAW, 0);
    rd(OFS_DUR_RAW, 1);
    wr(OFS_DUR_RAW, 4095);
    rd(OFS_DUR_RAW, 4095);
    wr(OFS_DLY_TB, 0);
    rd(OFS_DLY_TB, 1);
    wr(OFS_DUR_TB, 0);
    rd(OFS_DUR_TB, 1);
    for (int i = 0; i < 4; i++) begin
      wr(OFS_SEL, i);
      wr(OFS_DLY_RAW, 100 + i);
    end
    for (int i = 0; i < 4; i++) begin
      wr(OFS_SEL, i);
      rd(OFS_DLY_RAW, 100 + i);
    end
    $display("test limits and select done");
    wr(OFS_DLY_TB, 50);
    wr(OFS_SEL, 2);
    wr(OFS_DLY_US, 125);
    rd(OFS_DLY_RAW, 3);
    rd(OFS_DLY_US, 150);
    wr(OFS_DLY_RAW, 7);
    rd(OFS_DLY_US, 350);
    wr(OFS_SEL, 1);
    rd(OFS_DLY_US, 5050);
    wr(OFS_DUR_TB, 50);
    wr(OFS_DUR_US, 100);
    rd(OFS_DUR_RAW, 2);
    wr(OFS_DUR_RAW, 9);
    rd(OFS_DUR_US, 450);
    wr(OFS_SEL, 0);
    rd(OFS_DUR_US, 204750);
    $display("test microsecond views done");
    repeat (6) begin
      t = $urandom_range(1, 4);
      r = $urandom_range(0, 4095);
      d = $urandom_range(1, 4095);
      wr(OFS_SEL, $urandom_range(0, 3));
      wr(OFS_DLY_TB, t);
      wr(OFS_DUR_TB, t + 1);
      wr(OFS_DLY_RAW, r);
      wr(OFS_DUR_RAW, d);
      rd(OFS_DLY_US, r * t);
      rd(OFS_DUR_US, d * (t + 1));
      wr(OFS_DLY_US, ((r + 1) % 4096) * t);
      rd(OFS_DLY_RAW, (r + 1) % 4096);
    end
    $display("test random views done");
    pulses(2, 3, 1, '{1, 2, 3, 4});
    pulses(1, 1, 2, '{0, 5, 10, 15});
    end_of_test();
  end

  initial begin
    #1_000_000;
    bad("watchdog");
    end_of_test();
  end
endmodule
